//--- rtl/arc_pkg.sv
// Constants, field layouts and carrier types of the analog routing register group.
// Assumes a single register clock; every user of these names imports the whole package.
package arc_pkg;

  // ***************************************************************
  // Register map (indices; byte address is four times the index)
  // ***************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam logic [5:0] IDX_ROUTING = 6'h0d;
  localparam logic [5:0] IDX_MAGNITUDE = 6'h0e;
  localparam logic [5:0] IDX_REFSEL = 6'h0f;
  localparam logic [5:0] IDX_STATUS = 6'h14;

  // ***************************************************************
  // Reset values and write masks
  // ***************************************************************
  localparam logic [7:0] RST_ROUTING = 8'hbb;
  localparam logic [7:0] RST_MAGNITUDE = 8'h00;
  localparam logic [7:0] RST_REFSEL = 8'h00;
  localparam logic [7:0] REFSEL_WR_MASK = 8'h3f;

  // ***************************************************************
  // Field positions and widths
  // ***************************************************************
  localparam int SRC_FIELD_W = 4;
  localparam int REF_FIELD_W = 3;
  localparam int SECOND_FIELD_LSB = 4;
  localparam int FIRST_FIELD_LSB = 0;
  localparam int POS_REF_LSB = 3;
  localparam int NEG_REF_LSB = 0;

  // ***************************************************************
  // Codes and decoded switch counts
  // ***************************************************************
  localparam logic [3:0] PIN_CODE_FIRST = 4'h0;
  localparam logic [3:0] PIN_CODE_NONE = 4'hb;
  localparam logic [3:0] LEVEL_CODE_OFF = 4'h0;
  localparam logic [3:0] LEVEL_CODE_FIRST = 4'h1;
  localparam logic [3:0] LEVEL_CODE_MAX = 4'ha;
  localparam logic [2:0] REF_CODE_FIRST = 3'h0;
  localparam logic [2:0] REF_CODE_MAX = 3'h4;
  localparam int N_PINS = 11;
  localparam int N_STEPS = 10;
  localparam int N_REFS = 5;

  // ***************************************************************
  // Status register bit positions
  // ***************************************************************
  localparam int ST_FIRST_PIN_RSV = 0;
  localparam int ST_SECOND_PIN_RSV = 1;
  localparam int ST_FIRST_LVL_RSV = 2;
  localparam int ST_SECOND_LVL_RSV = 3;
  localparam int ST_POS_REF_RSV = 4;
  localparam int ST_NEG_REF_RSV = 5;
  localparam int ST_FIRST_ACTIVE = 6;
  localparam int ST_SECOND_ACTIVE = 7;

  // Switch enables of one excitation source
  typedef struct packed {
    logic [N_STEPS-1:0] step_en;
    logic [N_PINS-1:0] pin_en;
  } arc_source_sw_t;

  // Switch enables of the reference pair
  typedef struct packed {
    logic [N_REFS-1:0] pos_en;
    logic [N_REFS-1:0] neg_en;
  } arc_ref_sw_t;

  // Bus handshake states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_ACK = 1'b1
  } arc_bus_state_t;

endpackage

//--- rtl/arc_code_decoder.sv
// Registered one-hot decoder turning a stored field code into switch enables.
// Assumes the code input comes from a register on the same clock.
`timescale 1ns/1ps
module arc_code_decoder
  import arc_pkg::*;
#(
  parameter int CODE_W = 4,
  parameter int N_OUT = 11,
  parameter int BASE = 0,
  parameter int LAST_LEGAL = 11,
  parameter logic [CODE_W-1:0] RESET_CODE = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [CODE_W-1:0] code_i,
  output logic [N_OUT-1:0] en_o,
  output logic reserved_o
);

  // ***************************************************************
  // Decode function
  // ***************************************************************
  // Codes outside BASE..BASE+N_OUT-1 close no switch at all
  function automatic logic [N_OUT-1:0] decode(input logic [CODE_W-1:0] code);
    logic [N_OUT-1:0] en;
    en = '0;
    for (int i = 0; i < N_OUT; i++) begin
      en[i] = (int'(code) == BASE + i);
    end
    return en;
  endfunction

  // Enables flopped so the top drives them straight from flip-flops
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_o <= decode(RESET_CODE);
    end else begin
      en_o <= decode(code_i);
    end
  end

  // Reserved flag follows the stored code one edge later
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reserved_o <= (int'(RESET_CODE) > LAST_LEGAL);
    end else begin
      reserved_o <= (int'(code_i) > LAST_LEGAL);
    end
  end

endmodule

//--- rtl/arc_routing_regs.sv
// Top of the analog routing register group: Avalon-MM slave, three config registers,
// a status register and the decoded switch enables for sources and reference.
// Assumes a synchronous Avalon-MM master on CLK_I with byte addressing.
// Function
// - Bits 7:4 route second source, pins 0-9, common
// - Bits 3:0 route first source, same mapping
// - Code 1011 disconnects, reset value, reserved codes open
// - Bits 7:4 set second source current, 0 off
// - Bits 3:0 set first source current, same coding
// - Bits 5:3 choose positive reference input
// - Bits 2:0 choose negative reference input
// - Reference fields reset to internal reference pair
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
module arc_routing_regs
  import arc_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [DATA_W-1:0] AVS_WRITEDATA_I,
  input wire logic [BE_W-1:0] AVS_BYTEENABLE_I,
  output logic [DATA_W-1:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  output arc_source_sw_t FIRST_SOURCE_O,
  output arc_source_sw_t SECOND_SOURCE_O,
  output arc_ref_sw_t REFERENCE_O
);

  // ***************************************************************
  // Address decode helpers
  // ***************************************************************
  // Full byte address must match; low two bits must be zero
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [5:0] idx);
    return addr == {idx, 2'b00};
  endfunction

  // ***************************************************************
  // Declarations
  // ***************************************************************
  arc_bus_state_t state_q;
  arc_bus_state_t state_d;
  logic waitrequest_q;
  logic [DATA_W-1:0] readdata_q;
  logic [7:0] routing_q;
  logic [7:0] magnitude_q;
  logic [7:0] refsel_q;
  logic [7:0] status_w;
  logic [7:0] read_mux;
  logic req;
  logic wr_take;
  logic [7:0] wr_byte;
  logic [N_PINS-1:0] first_pin_en;
  logic [N_PINS-1:0] second_pin_en;
  logic [N_STEPS-1:0] first_step_en;
  logic [N_STEPS-1:0] second_step_en;
  logic [N_REFS-1:0] pos_ref_en;
  logic [N_REFS-1:0] neg_ref_en;
  logic first_pin_rsv;
  logic second_pin_rsv;
  logic first_lvl_rsv;
  logic second_lvl_rsv;
  logic pos_ref_rsv;
  logic neg_ref_rsv;

  // ***************************************************************
  // Bus handshake
  // ***************************************************************
  // Request seen in idle gets one wait cycle, then completes in ack.
  // The fixed single wait state keeps read data registered at no cost in logic.
  assign req = AVS_READ_I | AVS_WRITE_I;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (req) begin
          state_d = ST_ACK;
        end
      end
      ST_ACK: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Waitrequest drops for exactly the ack cycle; held high through reset
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      waitrequest_q <= 1'b1;
    end else begin
      waitrequest_q <= !(state_q == ST_IDLE && req);
    end
  end

  // Write commits on the edge where the master sees waitrequest low
  assign wr_take = (state_q == ST_ACK) && AVS_WRITE_I && AVS_BYTEENABLE_I[0];
  assign wr_byte = AVS_WRITEDATA_I[7:0];

  // ***************************************************************
  // Configuration registers
  // ***************************************************************
  // Routing register; any code is stored as written, reserved ones included
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      routing_q <= RST_ROUTING;
    end else if (wr_take && addr_hit(AVS_ADDRESS_I, IDX_ROUTING)) begin
      routing_q <= wr_byte;
    end
  end

  // Magnitude register
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      magnitude_q <= RST_MAGNITUDE;
    end else if (wr_take && addr_hit(AVS_ADDRESS_I, IDX_MAGNITUDE)) begin
      magnitude_q <= wr_byte;
    end
  end

  // Reference select; the two top bits never store anything
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      refsel_q <= RST_REFSEL;
    end else if (wr_take && addr_hit(AVS_ADDRESS_I, IDX_REFSEL)) begin
      refsel_q <= wr_byte & REFSEL_WR_MASK;
    end
  end

  // ***************************************************************
  // Status and read path
  // ***************************************************************
  // Reserved flags plus whether each source is both routed and powered
  always_comb begin
    status_w = 8'h00;
    status_w[ST_FIRST_PIN_RSV] = first_pin_rsv;
    status_w[ST_SECOND_PIN_RSV] = second_pin_rsv;
    status_w[ST_FIRST_LVL_RSV] = first_lvl_rsv;
    status_w[ST_SECOND_LVL_RSV] = second_lvl_rsv;
    status_w[ST_POS_REF_RSV] = pos_ref_rsv;
    status_w[ST_NEG_REF_RSV] = neg_ref_rsv;
    status_w[ST_FIRST_ACTIVE] = (|first_pin_en) & (|first_step_en);
    status_w[ST_SECOND_ACTIVE] = (|second_pin_en) & (|second_step_en);
  end

  // Unmapped addresses read as zero
  always_comb begin
    read_mux = 8'h00;
    if (addr_hit(AVS_ADDRESS_I, IDX_ROUTING)) begin
      read_mux = routing_q;
    end else if (addr_hit(AVS_ADDRESS_I, IDX_MAGNITUDE)) begin
      read_mux = magnitude_q;
    end else if (addr_hit(AVS_ADDRESS_I, IDX_REFSEL)) begin
      read_mux = refsel_q & REFSEL_WR_MASK;
    end else if (addr_hit(AVS_ADDRESS_I, IDX_STATUS)) begin
      read_mux = status_w;
    end
  end

  // Read data captured entering ack, so it stands through the ack cycle
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      readdata_q <= '0;
    end else if (state_q == ST_IDLE && AVS_READ_I) begin
      readdata_q <= {{(DATA_W-8){1'b0}}, read_mux};
    end
  end

  // ***************************************************************
  // Switch decoders
  // ***************************************************************
  // Second source pin routing: codes 0-10 close one pin, 11 none
  arc_code_decoder #(
    .CODE_W(SRC_FIELD_W),
    .N_OUT(N_PINS),
    .BASE(int'(PIN_CODE_FIRST)),
    .LAST_LEGAL(int'(PIN_CODE_NONE)),
    .RESET_CODE(RST_ROUTING[SECOND_FIELD_LSB +: SRC_FIELD_W])
  ) u_second_pin (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .code_i(routing_q[SECOND_FIELD_LSB +: SRC_FIELD_W]),
    .en_o(second_pin_en),
    .reserved_o(second_pin_rsv)
  );

  // First source pin routing
  arc_code_decoder #(
    .CODE_W(SRC_FIELD_W),
    .N_OUT(N_PINS),
    .BASE(int'(PIN_CODE_FIRST)),
    .LAST_LEGAL(int'(PIN_CODE_NONE)),
    .RESET_CODE(RST_ROUTING[FIRST_FIELD_LSB +: SRC_FIELD_W])
  ) u_first_pin (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .code_i(routing_q[FIRST_FIELD_LSB +: SRC_FIELD_W]),
    .en_o(first_pin_en),
    .reserved_o(first_pin_rsv)
  );

  // Second source current step: code 0 off, 1-10 one step each
  arc_code_decoder #(
    .CODE_W(SRC_FIELD_W),
    .N_OUT(N_STEPS),
    .BASE(int'(LEVEL_CODE_FIRST)),
    .LAST_LEGAL(int'(LEVEL_CODE_MAX)),
    .RESET_CODE(RST_MAGNITUDE[SECOND_FIELD_LSB +: SRC_FIELD_W])
  ) u_second_level (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .code_i(magnitude_q[SECOND_FIELD_LSB +: SRC_FIELD_W]),
    .en_o(second_step_en),
    .reserved_o(second_lvl_rsv)
  );

  // First source current step
  arc_code_decoder #(
    .CODE_W(SRC_FIELD_W),
    .N_OUT(N_STEPS),
    .BASE(int'(LEVEL_CODE_FIRST)),
    .LAST_LEGAL(int'(LEVEL_CODE_MAX)),
    .RESET_CODE(RST_MAGNITUDE[FIRST_FIELD_LSB +: SRC_FIELD_W])
  ) u_first_level (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .code_i(magnitude_q[FIRST_FIELD_LSB +: SRC_FIELD_W]),
    .en_o(first_step_en),
    .reserved_o(first_lvl_rsv)
  );

  // Positive reference: internal, in0, in2, in4, analog supply
  arc_code_decoder #(
    .CODE_W(REF_FIELD_W),
    .N_OUT(N_REFS),
    .BASE(int'(REF_CODE_FIRST)),
    .LAST_LEGAL(int'(REF_CODE_MAX)),
    .RESET_CODE(RST_REFSEL[POS_REF_LSB +: REF_FIELD_W])
  ) u_pos_ref (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .code_i(refsel_q[POS_REF_LSB +: REF_FIELD_W]),
    .en_o(pos_ref_en),
    .reserved_o(pos_ref_rsv)
  );

  // Negative reference: internal, in1, in3, in5, analog ground
  arc_code_decoder #(
    .CODE_W(REF_FIELD_W),
    .N_OUT(N_REFS),
    .BASE(int'(REF_CODE_FIRST)),
    .LAST_LEGAL(int'(REF_CODE_MAX)),
    .RESET_CODE(RST_REFSEL[NEG_REF_LSB +: REF_FIELD_W])
  ) u_neg_ref (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .code_i(refsel_q[NEG_REF_LSB +: REF_FIELD_W]),
    .en_o(neg_ref_en),
    .reserved_o(neg_ref_rsv)
  );

  // ***************************************************************
  // Outputs
  // ***************************************************************
  // All outputs are flip-flop outputs passed through as wires
  assign AVS_READDATA_O = readdata_q;
  assign AVS_WAITREQUEST_O = waitrequest_q;
  assign FIRST_SOURCE_O.pin_en = first_pin_en;
  assign FIRST_SOURCE_O.step_en = first_step_en;
  assign SECOND_SOURCE_O.pin_en = second_pin_en;
  assign SECOND_SOURCE_O.step_en = second_step_en;
  assign REFERENCE_O.pos_en = pos_ref_en;
  assign REFERENCE_O.neg_en = neg_ref_en;

endmodule

//--- testbench/arc_routing_regs_props.sv
// Checker of the analog routing register group, seen only through its top ports.
// Assumes it is bound into arc_routing_regs; one clock, reset RST_I.
`timescale 1ns/1ps
module arc_routing_regs_props
  import arc_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [DATA_W-1:0] AVS_WRITEDATA_I,
  input wire logic [BE_W-1:0] AVS_BYTEENABLE_I,
  input wire logic [DATA_W-1:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire arc_source_sw_t FIRST_SOURCE_O,
  input wire arc_source_sw_t SECOND_SOURCE_O,
  input wire arc_ref_sw_t REFERENCE_O
);
  // ***************************************************************
  // Accepted writes per register
  // ***************************************************************
  logic wr_ok;
  logic wr_rt;
  logic wr_mg;
  logic wr_rf;
  // Byte lane 0 must be enabled, else the write is dropped
  assign wr_ok = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0];
  assign wr_rt = wr_ok && AVS_ADDRESS_I == 8'h34;
  assign wr_mg = wr_ok && AVS_ADDRESS_I == 8'h38;
  assign wr_rf = wr_ok && AVS_ADDRESS_I == 8'h3c;

  // Expected one-hot; codes above top close nothing
  function automatic logic [15:0] hot(input logic [3:0] c, input logic [3:0] top);
    hot = (c <= top) ? (16'h1 << c) : 16'h0;
  endfunction

  // ***************************************************************
  // Properties
  // ***************************************************************
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  // Outputs lag the register by one edge, so check two edges on
  chk_wait_answer: assert property ((AVS_READ_I || AVS_WRITE_I) |-> ##[0:1] !AVS_WAITREQUEST_O)
    else $error("request not answered in one cycle");
  chk_wait_single: assert property ($fell(AVS_WAITREQUEST_O) |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low for more than one cycle");
  chk_second_pin: assert property (wr_rt |-> ##2
    SECOND_SOURCE_O.pin_en == hot($past(AVS_WRITEDATA_I[7:4], 2), 4'ha))
    else $error("second source pin decode wrong");
  chk_first_pin: assert property (wr_rt |-> ##2
    FIRST_SOURCE_O.pin_en == hot($past(AVS_WRITEDATA_I[3:0], 2), 4'ha))
    else $error("first source pin decode wrong");
  chk_reset_open: assert property ($fell(RST_I) |->
    (FIRST_SOURCE_O.pin_en == 11'h0) && (SECOND_SOURCE_O.pin_en == 11'h0))
    else $error("source pins not open after reset");
  chk_second_level: assert property (wr_mg |-> ##2
    SECOND_SOURCE_O.step_en == (hot($past(AVS_WRITEDATA_I[7:4], 2), 4'ha) >> 1))
    else $error("second source level decode wrong");
  chk_first_level: assert property (wr_mg |-> ##2
    FIRST_SOURCE_O.step_en == (hot($past(AVS_WRITEDATA_I[3:0], 2), 4'ha) >> 1))
    else $error("first source level decode wrong");
  chk_pos_ref: assert property (wr_rf |-> ##2
    REFERENCE_O.pos_en == hot({1'b0, $past(AVS_WRITEDATA_I[5:3], 2)}, 4'h4))
    else $error("positive reference decode wrong");
  chk_neg_ref: assert property (wr_rf |-> ##2
    REFERENCE_O.neg_en == hot({1'b0, $past(AVS_WRITEDATA_I[2:0], 2)}, 4'h4))
    else $error("negative reference decode wrong");
  chk_ref_reset: assert property ($fell(RST_I) |-> REFERENCE_O == 10'h021)
    else $error("reference pair not internal after reset");
  chk_ref_top_zero: assert property ((AVS_READ_I && !AVS_WAITREQUEST_O &&
    AVS_ADDRESS_I == 8'h3c) |-> AVS_READDATA_O[7:6] == 2'b00)
    else $error("reference top bits read nonzero");
  chk_fields_onehot: assert property ($onehot0(FIRST_SOURCE_O.pin_en) &&
    $onehot0(SECOND_SOURCE_O.pin_en) && $onehot0(FIRST_SOURCE_O.step_en) &&
    $onehot0(SECOND_SOURCE_O.step_en) && $onehot0(REFERENCE_O.pos_en) &&
    $onehot0(REFERENCE_O.neg_en))
    else $error("more than one switch closed in a field");
endmodule

bind arc_routing_regs arc_routing_regs_props u_props (.CLK_I(CLK_I), .RST_I(RST_I),
  .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
  .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .FIRST_SOURCE_O(FIRST_SOURCE_O), .SECOND_SOURCE_O(SECOND_SOURCE_O),
  .REFERENCE_O(REFERENCE_O));

//--- testbench/arc_routing_regs_tb.sv
// Self-checking bench of the analog routing register group.
// Assumes the checker is bound in; drives Avalon-MM at rising edges only.
`timescale 1ns/1ps
module arc_routing_regs_tb
  import arc_pkg::*;
;
  logic CLK_I = 1'b0;
  logic RST_I = 1'b1;
  logic [ADDR_W-1:0] AVS_ADDRESS_I = 8'h00;
  logic AVS_READ_I = 1'b0;
  logic AVS_WRITE_I = 1'b0;
  logic [DATA_W-1:0] AVS_WRITEDATA_I = 32'h0;
  logic [BE_W-1:0] AVS_BYTEENABLE_I = 4'h0;
  logic [DATA_W-1:0] AVS_READDATA_O;
  logic AVS_WAITREQUEST_O;
  arc_source_sw_t FIRST_SOURCE_O;
  arc_source_sw_t SECOND_SOURCE_O;
  arc_ref_sw_t REFERENCE_O;
  int fails = 0;
  int samples_checked = 0;
  logic [31:0] q;
  logic [7:0] v;

  arc_routing_regs DUT (.CLK_I(CLK_I), .RST_I(RST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
    .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
    .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .FIRST_SOURCE_O(FIRST_SOURCE_O),
    .SECOND_SOURCE_O(SECOND_SOURCE_O), .REFERENCE_O(REFERENCE_O));

  // ***************************************************************
  // Clock, verdict and checking helpers
  // ***************************************************************
  // 50 MHz register clock
  always #10 CLK_I = ~CLK_I;

  task automatic results();
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  function automatic logic [15:0] hot(input logic [3:0] c, input logic [3:0] top);
    hot = (c <= top) ? (16'h1 << c) : 16'h0;
  endfunction

  // One bus access: the request is raised just after a rising edge and held
  // until the rising edge at which waitrequest is sampled low; read data is
  // taken at that same edge and only then is the request dropped
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [31:0] rq);
    int n;
    n = 0;
    @(posedge CLK_I);
    AVS_ADDRESS_I <= a;
    AVS_WRITEDATA_I <= {24'h0, d};
    AVS_BYTEENABLE_I <= be;
    AVS_READ_I <= !w;
    AVS_WRITE_I <= w;
    do begin
      @(posedge CLK_I);
      n++;
    end while (AVS_WAITREQUEST_O !== 1'b0 && n < 50);
    // Bounded wait ran out without an answer
    if (AVS_WAITREQUEST_O !== 1'b0) begin
      fails++;
      results();
    end
    rq = AVS_READDATA_O;
    AVS_READ_I <= 1'b0;
    AVS_WRITE_I <= 1'b0;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge CLK_I);
    fails++;
    results();
  end

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  initial begin
    repeat (6) @(posedge CLK_I);
    RST_I <= 1'b0;
    acc(0, 8'h34, 8'h00, 4'h1, q);
    chk("routing reset", q, 32'hbb);
    chk("pins reset", 32'({FIRST_SOURCE_O.pin_en, SECOND_SOURCE_O.pin_en}), 32'h0);
    acc(0, 8'h38, 8'h00, 4'h1, q);
    chk("magnitude reset", q, 32'h0);
    chk("steps reset", 32'({FIRST_SOURCE_O.step_en, SECOND_SOURCE_O.step_en}), 32'h0);
    acc(0, 8'h3c, 8'h00, 4'h1, q);
    chk("refsel reset", q, 32'h0);
    chk("reference reset", 32'(REFERENCE_O), 32'h021);
    // Every routing and level code, reserved ones included, back to back
    for (int c = 0; c < 16; c++) begin
      v = {4'(15 - c), 4'(c)};
      acc(1, 8'h34, v, 4'h1, q);
      acc(0, 8'h34, 8'h00, 4'h1, q);
      chk("routing readback", q, {24'h0, v});
      chk("first pin", 32'(FIRST_SOURCE_O.pin_en), 32'(hot(v[3:0], 4'ha)));
      chk("second pin", 32'(SECOND_SOURCE_O.pin_en), 32'(hot(v[7:4], 4'ha)));
      acc(1, 8'h38, v, 4'h1, q);
      acc(0, 8'h38, 8'h00, 4'h1, q);
      chk("magnitude readback", q, {24'h0, v});
      chk("first level", 32'(FIRST_SOURCE_O.step_en), 32'(hot(v[3:0], 4'ha) >> 1));
      chk("second level", 32'(SECOND_SOURCE_O.step_en), 32'(hot(v[7:4], 4'ha) >> 1));
    end
    // Every reference code, with the top bits written as ones
    for (int c = 0; c < 8; c++) begin
      v = {2'b11, 3'(c), 3'(7 - c)};
      acc(1, 8'h3c, v, 4'h1, q);
      acc(0, 8'h3c, 8'h00, 4'h1, q);
      chk("refsel readback", q, {26'h0, v[5:0]});
      chk("positive ref", 32'(REFERENCE_O.pos_en), 32'(hot({1'b0, v[5:3]}, 4'h4)));
      chk("negative ref", 32'(REFERENCE_O.neg_en), 32'(hot({1'b0, v[2:0]}, 4'h4)));
    end
    // Lane 0 disabled and unmapped places must leave the registers alone
    acc(1, 8'h34, 8'h12, 4'he, q);
    acc(1, 8'h44, 8'h55, 4'h1, q);
    acc(0, 8'h34, 8'h00, 4'h1, q);
    chk("routing kept", q, 32'h0f);
    acc(0, 8'h44, 8'h00, 4'h1, q);
    chk("unmapped read", q, 32'h0);
    // Reserved first pin, first level and positive reference codes are left stored
    acc(0, 8'h50, 8'h00, 4'h1, q);
    chk("status", q, 32'h15);
    // Second reset in mid-run returns the defaults
    RST_I <= 1'b1;
    repeat (2) @(posedge CLK_I);
    RST_I <= 1'b0;
    acc(0, 8'h34, 8'h00, 4'h1, q);
    chk("routing rereset", q, 32'hbb);
    chk("reference rereset", 32'(REFERENCE_O), 32'h021);
    results();
  end
endmodule
